//--- rtl/uim_mask_logic.sv
// Interrupt enable, disable and mask registers with mode dependent layouts
`include "uim_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Disable write clears mask bits of the live layout written as one, leaves others.
// - Enable write sets mask bits of the live layout written as one, leaves others.
// - Mask read returns one per enabled source, zero otherwise.
// - Serial peripheral layout applies only for mode codes 0xE and 0xF.
// - Local interconnect layout applies only for mode codes 0xA and 0xB.
// - Serial peripheral layout places its eleven sources at the listed bit positions.
// - Local interconnect frame events at 13 to 15, errors at 25 to 31.
// - Local interconnect keeps framing, parity, timeout at 6, 7, 8.
// - Ordinary layout places break, errors, timeout, repetition, not_acknowledged, cts, compare.
// - Buffer end, empty and full masks exist in every layout.
// - Compare mask at 22 in ordinary and peripheral layouts, absent otherwise.
module uim_mask_logic
	import uim_pkg::*;
(
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	input  wire uim_bus_req_t bus_req_in,
	input  wire logic [3:0]   mode_in,
	input  wire logic [31:0]  status_in,
	output logic      [31:0]  rdata_out,
	output logic      [31:0]  mask_out,
	output uim_layout_t       layout_out,
	output logic              irq_out
);

	// Bits common to every layout
	wire [31:0] common_bits;
	assign common_bits =
		(32'h0000_0001 << `UIM_POS_RX_CHAR_READY) |
		(32'h0000_0001 << `UIM_POS_TX_HOLDING_FREE) |
		(32'h0000_0001 << `UIM_POS_OVERRUN_ERROR) |
		(32'h0000_0001 << `UIM_POS_TRANSMITTER_IDLE);

	// Buffer events stay in every layout
	wire [31:0] buffer_bits;
	assign buffer_bits =
		(32'h0000_0001 << `UIM_POS_RX_BUFFER_END) |
		(32'h0000_0001 << `UIM_POS_TX_BUFFER_END) |
		(32'h0000_0001 << `UIM_POS_TX_BUFFER_EMPTY) |
		(32'h0000_0001 << `UIM_POS_RX_BUFFER_FULL);

	// Receive errors shared by ordinary and interconnect layouts
	wire [31:0] rx_error_bits;
	assign rx_error_bits =
		(32'h0000_0001 << `UIM_POS_FRAMING_ERROR) |
		(32'h0000_0001 << `UIM_POS_PARITY_ERROR) |
		(32'h0000_0001 << `UIM_POS_RX_TIMEOUT);

	// Ordinary layout
	wire [31:0] normal_bits;
	assign normal_bits = common_bits | buffer_bits | rx_error_bits |
		(32'h0000_0001 << `UIM_POS_BREAK_RECEIVED) |
		(32'h0000_0001 << `UIM_POS_REPETITION_LIMIT) |
		(32'h0000_0001 << `UIM_POS_NOT_ACKNOWLEDGED) |
		(32'h0000_0001 << `UIM_POS_CTS_CHANGE) |
		(32'h0000_0001 << `UIM_POS_CHAR_COMPARE);

	// Serial peripheral layout
	wire [31:0] spi_bits;
	assign spi_bits = common_bits | buffer_bits |
		(32'h0000_0001 << `UIM_POS_SPI_UNDERRUN) |
		(32'h0000_0001 << `UIM_POS_SLAVE_SELECT) |
		(32'h0000_0001 << `UIM_POS_CHAR_COMPARE);

	// Interconnect layout; compare match has no place here
	wire [31:0] lin_bits;
	assign lin_bits = common_bits | buffer_bits | rx_error_bits |
		(32'h0000_0001 << `UIM_POS_BREAK_FIELD_DONE) |
		(32'h0000_0001 << `UIM_POS_IDENTIFIER_DONE) |
		(32'h0000_0001 << `UIM_POS_TRANSFER_COMPLETE) |
		(32'h0000_0001 << `UIM_POS_BUS_ERROR) |
		(32'h0000_0001 << `UIM_POS_SYNC_INCONSISTENT) |
		(32'h0000_0001 << `UIM_POS_ID_PARITY_ERROR) |
		(32'h0000_0001 << `UIM_POS_CHECKSUM_ERROR) |
		(32'h0000_0001 << `UIM_POS_SLAVE_NO_RESPONSE) |
		(32'h0000_0001 << `UIM_POS_SYNC_TOLERANCE) |
		(32'h0000_0001 << `UIM_POS_HEADER_TIMEOUT);

	// Layout follows the mode field live
	wire         mode_spi;
	wire         mode_lin;
	uim_layout_t layout;
	assign mode_spi = (mode_in == `UIM_MODE_SPI_A) || (mode_in == `UIM_MODE_SPI_B);
	assign mode_lin = (mode_in == `UIM_MODE_LIN_A) || (mode_in == `UIM_MODE_LIN_B);
	assign layout   = mode_spi ? UIM_LAYOUT_SPI :
		(mode_lin ? UIM_LAYOUT_LIN : UIM_LAYOUT_NORMAL);

	// Bits that exist under the current layout
	wire [31:0] valid_bits;
	assign valid_bits = (layout == UIM_LAYOUT_SPI) ? spi_bits :
		((layout == UIM_LAYOUT_LIN) ? lin_bits : normal_bits);

	// Address decode
	wire hit_enable;
	wire hit_disable;
	wire hit_mask;
	wire hit_event;
	assign hit_enable  = (bus_req_in.addr == `UIM_OFS_ENABLE);
	assign hit_disable = (bus_req_in.addr == `UIM_OFS_DISABLE);
	assign hit_mask    = (bus_req_in.addr == `UIM_OFS_MASK);
	assign hit_event   = (bus_req_in.addr == `UIM_OFS_EVENT);

	// Write effects; mask writes limited to bits of the live layout, event clear is not
	wire [31:0] wr_bits;
	wire [31:0] mask_set;
	wire [31:0] mask_clr;
	wire [31:0] event_clr;
	assign wr_bits   = bus_req_in.wdata & valid_bits;
	assign mask_set  = (bus_req_in.wr && hit_enable) ? wr_bits : 32'h0000_0000;
	assign mask_clr  = (bus_req_in.wr && hit_disable) ? wr_bits : 32'h0000_0000;
	assign event_clr = (bus_req_in.wr && hit_event) ? bus_req_in.wdata : 32'h0000_0000;

	// Mask storage; bits hidden by a layout keep their value
	logic [31:0] mask_q;
	uim_setclr_reg #(
		.WIDTH (32),
		.RESET (`UIM_MASK_RESET)
	) u_mask (
		.mclk_in   (mclk_in),
		.nrst_in   (nrst_in),
		.set_in    (mask_set),
		.clr_in    (mask_clr),
		.value_out (mask_q)
	);

	// Sticky event capture of the unit's flags, cleared by writing one
	logic [31:0] event_q;
	wire  [31:0] event_set;
	assign event_set = status_in & valid_bits;
	uim_setclr_reg #(
		.WIDTH (32),
		.RESET (`UIM_EVENT_RESET)
	) u_event (
		.mclk_in   (mclk_in),
		.nrst_in   (nrst_in),
		.set_in    (event_set),
		.clr_in    (event_clr),
		.value_out (event_q)
	);

	// Views as software sees them
	wire [31:0] mask_view;
	wire [31:0] event_view;
	assign mask_view  = mask_q & valid_bits;
	assign event_view = event_q & valid_bits;

	// Read mux; write-only and unmapped words read as zero
	wire [31:0] rdata_d;
	assign rdata_d = !bus_req_in.rd ? 32'h0000_0000 :
		(hit_mask ? mask_view :
		(hit_event ? event_view : 32'h0000_0000));

	// Request from live flags or captured events, so a short pulse still counts
	wire irq_d;
	assign irq_d = |((status_in | event_q) & mask_view);

	// Output registers
	logic [31:0] rdata_q;
	logic [31:0] mask_out_q;
	logic        irq_q;
	uim_layout_t layout_q;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			rdata_q <= `UIM_RDATA_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Mask and layout mirrors for the rest of the unit
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			mask_out_q <= `UIM_MASK_RESET;
			layout_q   <= UIM_LAYOUT_NORMAL;
		end else begin
			mask_out_q <= mask_view;
			layout_q   <= layout;
		end
	end

	// Registered request costs one cycle but keeps the line glitch free
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign rdata_out  = rdata_q;
	assign mask_out   = mask_out_q;
	assign layout_out = layout_q;
	assign irq_out    = irq_q;

endmodule : uim_mask_logic

`default_nettype wire

//--- rtl/uim_defs.svh
// Register offsets, field positions, mode codes and reset values of the interrupt mask logic
`ifndef UIM_DEFS_SVH
`define UIM_DEFS_SVH

// Register byte addresses
`define UIM_OFS_ENABLE        32'h4000_C208
`define UIM_OFS_DISABLE       32'h4000_C20C
`define UIM_OFS_MASK          32'h4000_C210
`define UIM_OFS_EVENT         32'h4000_C2F0

// Mode field codes
`define UIM_MODE_LIN_A        4'hA
`define UIM_MODE_LIN_B        4'hB
`define UIM_MODE_SPI_A        4'hE
`define UIM_MODE_SPI_B        4'hF

// Reset values
`define UIM_MASK_RESET        32'h0000_0000
`define UIM_EVENT_RESET       32'h0000_0000
`define UIM_RDATA_RESET       32'h0000_0000

// Bit positions shared by every layout
`define UIM_POS_RX_CHAR_READY     0
`define UIM_POS_TX_HOLDING_FREE   1
`define UIM_POS_RX_BUFFER_END     3
`define UIM_POS_TX_BUFFER_END     4
`define UIM_POS_OVERRUN_ERROR     5
`define UIM_POS_TRANSMITTER_IDLE  9
`define UIM_POS_TX_BUFFER_EMPTY   11
`define UIM_POS_RX_BUFFER_FULL    12

// Ordinary layout
`define UIM_POS_BREAK_RECEIVED    2
`define UIM_POS_FRAMING_ERROR     6
`define UIM_POS_PARITY_ERROR      7
`define UIM_POS_RX_TIMEOUT        8
`define UIM_POS_REPETITION_LIMIT  10
`define UIM_POS_NOT_ACKNOWLEDGED  13
`define UIM_POS_CTS_CHANGE        19
`define UIM_POS_CHAR_COMPARE      22

// Serial peripheral layout
`define UIM_POS_SPI_UNDERRUN      10
`define UIM_POS_SLAVE_SELECT      19

// Local interconnect layout
`define UIM_POS_BREAK_FIELD_DONE  13
`define UIM_POS_IDENTIFIER_DONE   14
`define UIM_POS_TRANSFER_COMPLETE 15
`define UIM_POS_BUS_ERROR         25
`define UIM_POS_SYNC_INCONSISTENT 26
`define UIM_POS_ID_PARITY_ERROR   27
`define UIM_POS_CHECKSUM_ERROR    28
`define UIM_POS_SLAVE_NO_RESPONSE 29
`define UIM_POS_SYNC_TOLERANCE    30
`define UIM_POS_HEADER_TIMEOUT    31

`endif

//--- rtl/uim_pkg.sv
// Types of the interrupt mask logic
package uim_pkg;

	// Register bus request, one cycle per access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} uim_bus_req_t;

	// Active bit layout, Gray coded
	typedef enum logic [1:0] {
		UIM_LAYOUT_NORMAL = 2'b00,
		UIM_LAYOUT_LIN    = 2'b01,
		UIM_LAYOUT_SPI    = 2'b11
	} uim_layout_t;

endpackage : uim_pkg

//--- rtl/uim_setclr_reg.sv
// Bit vector register with set and clear inputs where set wins
`timescale 1ns/1ps
`default_nettype none

module uim_setclr_reg #(
	parameter int          WIDTH = 32,
	parameter logic [31:0] RESET = 32'h0000_0000
) (
	input  wire logic             mclk_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clr_in,
	output logic      [WIDTH-1:0] value_out
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	// Set beats a clear in the same cycle so no event is lost
	assign value_d   = set_in | (value_q & ~clr_in);
	assign value_out = value_q;

	// Synchronous active low reset
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			value_q <= RESET[WIDTH-1:0];
		end else begin
			value_q <= value_d;
		end
	end

endmodule : uim_setclr_reg

`default_nettype wire

//--- testbench/uim_mask_chk.sv
// Concurrent checks of the interrupt mask logic ports
`include "uim_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uim_mask_chk
	import uim_pkg::*;
(
	input wire logic         mclk_in,
	input wire logic         nrst_in,
	input wire uim_bus_req_t bus_req_in,
	input wire logic [3:0]   mode_in,
	input wire logic [31:0]  status_in,
	input wire logic [31:0]  rdata_out,
	input wire logic [31:0]  mask_out,
	input wire uim_layout_t  layout_out,
	input wire logic         irq_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// Bits each layout carries
	function automatic logic [31:0] bits(uim_layout_t l);
		return l == UIM_LAYOUT_SPI ? 32'h0048_1E3B :
			l == UIM_LAYOUT_LIN ? 32'hFE00_FBFB : 32'h0048_3FFF;
	endfunction : bits
	function automatic uim_layout_t pick(logic [3:0] m);
		return m[3:1] == 3'b111 ? UIM_LAYOUT_SPI :
			m[3:1] == 3'b101 ? UIM_LAYOUT_LIN : UIM_LAYOUT_NORMAL;
	endfunction : pick
	// Access decode
	wire logic en_wr  = bus_req_in.wr && bus_req_in.addr == `UIM_OFS_ENABLE;
	wire logic dis_wr = bus_req_in.wr && bus_req_in.addr == `UIM_OFS_DISABLE;
	wire logic m_rd   = bus_req_in.rd && bus_req_in.addr == `UIM_OFS_MASK;
	wire logic o_rd   = bus_req_in.rd && !m_rd && bus_req_in.addr != `UIM_OFS_EVENT;
	a_layout_code: assert property ($past(nrst_in) |-> layout_out == pick($past(mode_in)))
		else $error("layout does not follow mode");
	a_mask_layout: assert property ((mask_out & ~bits(layout_out)) == 32'h0000_0000)
		else $error("mask bit outside layout");
	// Mode held steady so the layout seen later is the one the write met
	a_enable_sets: assert property ($stable(mode_in) && en_wr ##1 $stable(mode_in) [*2] |->
		(mask_out & $past(bus_req_in.wdata, 2) & bits(layout_out))
		== ($past(bus_req_in.wdata, 2) & bits(layout_out)))
		else $error("enable write did not set");
	a_disable_clrs: assert property (dis_wr ##1 $stable(mode_in) [*2] |->
		(mask_out & $past(bus_req_in.wdata, 2)) == 32'h0000_0000)
		else $error("disable write did not clear");
	a_mask_rdback: assert property (m_rd |=> rdata_out == mask_out)
		else $error("mask read mismatch");
	a_other_zero: assert property (o_rd |=> rdata_out == 32'h0000_0000)
		else $error("non mask read not zero");
	a_rdata_idle: assert property (!bus_req_in.rd |=> rdata_out == 32'h0000_0000)
		else $error("read data without read");
	a_irq_quiet: assert property ((mask_out == 32'h0000_0000 && $stable(mode_in)) [*2] |-> !irq_out)
		else $error("irq with empty mask");
	a_irq_raise: assert property ((status_in & mask_out) != 32'h0000_0000 ##1 $stable(mask_out)
		|-> irq_out)
		else $error("irq missing");
	c_mask_read: cover property (m_rd ##1 rdata_out != 32'h0000_0000);
	c_irq_rise: cover property ($rose(irq_out));
	c_lin_mask: cover property (layout_out == UIM_LAYOUT_LIN && mask_out != 32'h0000_0000);
endmodule : uim_mask_chk
bind uim_mask_logic uim_mask_chk u_chk (.mclk_in, .nrst_in, .bus_req_in, .mode_in, .status_in,
	.rdata_out, .mask_out, .layout_out, .irq_out);
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the interrupt mask logic
`include "uim_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import uim_pkg::*;
;
	localparam logic [31:0] A_EN = `UIM_OFS_ENABLE;
	localparam logic [31:0] A_DI = `UIM_OFS_DISABLE;
	localparam logic [31:0] A_MK = `UIM_OFS_MASK;
	logic         mclk_in     = 1'b0;
	logic         nrst_in     = 1'b0;
	uim_bus_req_t bus_req_in  = '0;
	logic [3:0]   mode_in     = 4'h0;
	logic [31:0]  status_in   = 32'h0000_0000;
	logic [31:0]  rdata_out;
	logic [31:0]  mask_out;
	uim_layout_t  layout_out;
	logic         irq_out;
	int           err_count   = 0;
	int           checks_done = 0;
	int           cycles      = 0;
	uim_mask_logic DUT (.mclk_in, .nrst_in, .bus_req_in, .mode_in, .status_in,
		.rdata_out, .mask_out, .layout_out, .irq_out);
	always #2.5 mclk_in = ~mclk_in;
	// Hang guard, far above the roughly 160 cycles needed
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Strobe lasts one cycle, released at the edge that takes it
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		bus_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk_in);
		bus_req_in <= '0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge mclk_in);
		bus_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge mclk_in);
		bus_req_in <= '0;
		#1 chk(rdata_out, exp);
	endtask : rd
	task automatic irq_is(input logic v);
		repeat (3) @(posedge mclk_in);
		#1 chk({31'h0000_0000, irq_out}, {31'h0000_0000, v});
	endtask : irq_is
	// Every mode code, then ordinary again through an unlisted code
	task automatic t_layouts();
		logic [3:0]  modes [6] = '{4'h0, 4'hA, 4'hE, 4'hB, 4'hF, 4'h5};
		logic [31:0] lay;
		logic [1:0]  code;
		foreach (modes[i]) begin
			lay = modes[i][3:1] == 3'b111 ? 32'h0048_1E3B :
				modes[i][3:1] == 3'b101 ? 32'hFE00_FBFB : 32'h0048_3FFF;
			code = modes[i][3:1] == 3'b111 ? 2'b11 : modes[i][3:1] == 3'b101 ? 2'b01 : 2'b00;
			@(posedge mclk_in);
			mode_in <= modes[i];
			wr(A_EN, 32'hFFFF_FFFF);
			rd(A_MK, lay);
			chk(mask_out, lay);
			chk({30'h0000_0000, layout_out}, {30'h0000_0000, code});
			wr(A_DI, 32'h0040_0005);
			rd(A_MK, lay & 32'hFFBF_FFFA);
			wr(A_EN, 32'h0000_0004);
			rd(A_MK, lay & 32'hFFBF_FFFE);
			wr(A_DI, 32'hFFFF_FFFF);
			rd(A_MK, 32'h0000_0000);
		end
	endtask : t_layouts
	// Mask is read-only, enable word and an unmapped word read zero
	task automatic t_refused();
		wr(A_MK, 32'hFFFF_FFFF);
		rd(A_MK, 32'h0000_0000);
		rd(A_EN, 32'h0000_0000);
		rd(32'h4000_C214, 32'h0000_0000);
	endtask : t_refused
	// Masked flag, sticky pulse, disable, clear, absent source
	task automatic t_irq();
		@(posedge mclk_in);
		mode_in <= 4'h0;
		status_in <= 32'h0000_0020;
		wr(A_EN, 32'h0000_0001);
		irq_is(1'b0);
		@(posedge mclk_in);
		status_in <= 32'h0000_0021;
		@(posedge mclk_in);
		status_in <= 32'h0000_0000;
		irq_is(1'b1);
		wr(A_DI, 32'h0000_0001);
		irq_is(1'b0);
		wr(`UIM_OFS_EVENT, 32'hFFFF_FFFF);
		wr(A_EN, 32'h0000_0001);
		irq_is(1'b0);
		@(posedge mclk_in);
		mode_in <= 4'hA;
		status_in <= 32'h0040_0000;
		wr(A_EN, 32'hFFFF_FFFF);
		irq_is(1'b0);
	endtask : t_irq
	// Reset in mid-run drops mask, events and request
	task automatic t_reset();
		@(posedge mclk_in);
		status_in <= 32'h0000_0001;
		irq_is(1'b1);
		@(posedge mclk_in);
		nrst_in   <= 1'b0;
		status_in <= 32'h0000_0000;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		#1 chk({31'h0000_0000, irq_out}, {31'h0000_0000, 1'b0});
		rd(A_MK, 32'h0000_0000);
		irq_is(1'b0);
	endtask : t_reset
	task automatic finish_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (6) @(posedge mclk_in);
		nrst_in <= 1'b1;
		rd(A_MK, 32'h0000_0000);
		t_layouts();
		t_refused();
		t_irq();
		t_reset();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
